//--- wlac_consts.svh
// Offsets, field positions, reset values and counts of the acquisition control.
// Included by the limit compare, the control and the testbench files.
`ifndef WLAC_CONSTS_SVH
`define WLAC_CONSTS_SVH
`define WLAC_OFF_CTRL      8'h00
`define WLAC_OFF_LIMFLAG   8'h04
`define WLAC_OFF_IRQ_STAT  8'h08
`define WLAC_OFF_IRQ_CLR   8'h0c
`define WLAC_OFF_IRQ_EN    8'h10
`define WLAC_OFF_SEQ_STAT  8'h14
`define WLAC_RAM_PAGE      3'h2
`define WLAC_CTRL_START    0
`define WLAC_CTRL_BANK_LO  8
`define WLAC_BANK_INSTR    2'h0
`define WLAC_BANK_LIM1     2'h1
`define WLAC_BANK_LIM2     2'h2
`define WLAC_INS_LOOP      0
`define WLAC_INS_PAUSE     1
`define WLAC_INS_POS_LO    2
`define WLAC_INS_NEG_LO    5
`define WLAC_INS_RES       10
`define WLAC_INS_WD        11
`define WLAC_INS_ACQ_LO    12
`define WLAC_LIM_SIGN      8
`define WLAC_LIM_DIR       9
`define WLAC_ACQ_BASE_FULL 6'h09
`define WLAC_ACQ_BASE_RED  6'h02
`define WLAC_IRQ_LIMIT     0
`define WLAC_IRQ_PAUSE     1
`define WLAC_IRQ_CONV      2
`define WLAC_RESET_WORD    16'h0000
`endif

//--- wlac_pkg.sv
// Types shared by the acquisition control files.
// Assumes the constants header is on the include path.
package wlac_pkg;
   typedef logic signed [8:0] wlac_sample_t;
   typedef logic [15:0]       wlac_word_t;
   typedef enum logic [2:0] {
      S_IDLE, S_LOAD, S_ACQ, S_CONV, S_CMP1, S_CMP2, S_NEXT
   } wlac_state_t;
endpackage

//--- wlac_mux_decode.sv
// Channel routing decode for the eight-input multiplexer.
// Assumes select codes come from a held instruction word.
module wlac_mux_decode #(
   parameter int SEL_W = 3
) (
   input  wire logic [SEL_W-1:0]      pos_sel_in,
   input  wire logic [SEL_W-1:0]      neg_sel_in,
   output logic      [(1<<SEL_W)-1:0] pos_route_out,
   output logic      [(1<<SEL_W)-1:0] neg_route_out,
   output logic                       neg_ground_out
);
   localparam int N = 1 << SEL_W;
   wire neg_zero_w = (neg_sel_in == '0);
   assign pos_route_out  = N'(1) << pos_sel_in;
   assign neg_route_out  = neg_zero_w ? '0 : (N'(1) << neg_sel_in);
   assign neg_ground_out = neg_zero_w;
endmodule // wlac_mux_decode

//--- wlac_limit_cmp.sv
// One watchdog limit comparison against a held sample.
// Assumes the sample is two's complement, limit word sign-magnitude.
`include "wlac_consts.svh"
module wlac_limit_cmp (
   input  wire logic                [15:0] limit_word_in,
   input  wire wlac_pkg::wlac_sample_t     sample_in,
   output logic                            crossed_out
);
   import wlac_pkg::*;
   logic signed [9:0] lim_w;
   logic signed [9:0] smp_w;
   wire [7:0] mag_w  = limit_word_in[7:0];
   wire       sign_w = limit_word_in[`WLAC_LIM_SIGN];
   wire       dir_w  = limit_word_in[`WLAC_LIM_DIR];
   assign lim_w = sign_w ? -$signed({2'b00, mag_w}) : $signed({2'b00, mag_w});
   assign smp_w = 10'(sample_in);
   assign crossed_out = dir_w ? (smp_w > lim_w) : (smp_w < lim_w);
endmodule // wlac_limit_cmp

//--- wlac_ctrl.sv
// Acquisition sequencing, channel routing and watchdog limit checking.
// Assumes an APB master on ref_clk_in and a converter that returns one
// sample with sample_valid_in after each conv_start_out pulse.
`include "wlac_consts.svh"
// Function
// - Limit one crossing sets bit n
// - Limit two crossing sets bit 8+n
// - Flags read only, set by hardware
// - Acquisition lasts 9+2D or 2+2D clocks
// - D is instruction bits 15 to 12
// - Bank pointer 01 maps first limits
// - Bank pointer 10 maps second limits
// - Limit magnitude bits 7-0, sign bit 8
// - Watchdog compares one sample twice
// - Limit one bit 9 picks direction
// - Limit two bit 9 picks direction
// - Select bits route inputs or ground
// - Sign zero positive, one negative
// - Any crossing sets interrupt flag zero
// - Bit 10 picks reduced resolution timing; bit 11 alone also picks 2+2D
module wlac_ctrl #(
   parameter int DEPTH = 8,
   parameter int IRQ_W = 3
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   psel_in,
   input  wire logic                   penable_in,
   input  wire logic                   pwrite_in,
   input  wire logic            [7:0]  paddr_in,
   input  wire logic            [31:0] pwdata_in,
   output logic                 [31:0] prdata_out,
   output logic                        pready_out,
   output logic                        pslverr_out,
   output logic                        irq_out,
   input  wire logic                   sample_valid_in,
   input  wire wlac_pkg::wlac_sample_t sample_in,
   output logic                        sh_acquire_out,
   output logic                        conv_start_out,
   output logic                        reduced_res_out,
   output logic                 [7:0]  pos_route_out,
   output logic                 [7:0]  neg_route_out,
   output logic                        neg_ground_out
);
   import wlac_pkg::*;

   wlac_word_t   instr_mem [DEPTH];
   wlac_word_t   lim1_mem  [DEPTH];
   wlac_word_t   lim2_mem  [DEPTH];
   wlac_state_t  state_q;
   wlac_state_t  state_d;
   logic [2:0]   ptr_q;
   logic [15:0]  instr_q;
   logic [5:0]   acq_cnt_q;
   wlac_sample_t sample_q;
   logic         run_q;
   logic [1:0]   bank_q;
   logic [15:0]  flags_q;
   logic [15:0]  flags_d;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_en_q;
   logic         irq_q;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         pslverr_q;
   logic         sh_acq_q;
   logic         conv_start_q;
   logic         reduced_q;
   logic [7:0]   pos_route_q;
   logic [7:0]   neg_route_q;
   logic         neg_gnd_q;
   logic [7:0]   pos_route_w;
   logic [7:0]   neg_route_w;
   logic         neg_gnd_w;
   logic         cross1_w;
   logic         cross2_w;

   // Bus decode
   wire        acc_w      = psel_in & penable_in;
   wire        answer_w   = acc_w & ~pready_q;
   wire        done_w     = acc_w & pready_q;
   wire        wr_done_w  = done_w & pwrite_in;
   wire        rd_done_w  = done_w & ~pwrite_in;
   wire        hit_ctrl_w = (paddr_in == `WLAC_OFF_CTRL);
   wire        hit_flag_w = (paddr_in == `WLAC_OFF_LIMFLAG);
   wire        hit_stat_w = (paddr_in == `WLAC_OFF_IRQ_STAT);
   wire        hit_clr_w  = (paddr_in == `WLAC_OFF_IRQ_CLR);
   wire        hit_en_w   = (paddr_in == `WLAC_OFF_IRQ_EN);
   wire        hit_seq_w  = (paddr_in == `WLAC_OFF_SEQ_STAT);
   wire        hit_ram_w  = (paddr_in[7:5] == `WLAC_RAM_PAGE) &&
                            (paddr_in[1:0] == 2'h0);
   wire [2:0]  ram_idx_w  = paddr_in[4:2];
   wire        mapped_w   = hit_ctrl_w | hit_flag_w | hit_stat_w |
                            hit_clr_w | hit_en_w | hit_seq_w | hit_ram_w;
   wire        ram_wr_w   = wr_done_w & hit_ram_w;

   wire [15:0] bank_rd_w  = (bank_q == `WLAC_BANK_INSTR) ? instr_mem[ram_idx_w] :
                            (bank_q == `WLAC_BANK_LIM1)  ? lim1_mem[ram_idx_w]  :
                            (bank_q == `WLAC_BANK_LIM2)  ? lim2_mem[ram_idx_w]  :
                            16'h0000;
   wire [31:0] ctrl_rd_w  = {22'h0, bank_q, 7'h0, run_q};
   wire [31:0] seq_rd_w   = {28'h0, (state_q != S_IDLE), ptr_q};
   wire [31:0] rd_data_w  = hit_ctrl_w ? ctrl_rd_w :
                            hit_flag_w ? {16'h0, flags_q} :
                            hit_stat_w ? {{(32-IRQ_W){1'b0}}, irq_stat_q} :
                            hit_en_w   ? {{(32-IRQ_W){1'b0}}, irq_en_q} :
                            hit_seq_w  ? seq_rd_w :
                            hit_ram_w  ? {16'h0, bank_rd_w} : 32'h0;

   // Sequencer inputs
   wire [15:0] ins_w      = instr_mem[ptr_q];
   // Routes and mode settle in LOAD, before the acquisition window opens
   wire [15:0] route_src_w = (state_q == S_LOAD) ? ins_w : instr_q;
   wire        ins_red_w  = ins_w[`WLAC_INS_RES] | ins_w[`WLAC_INS_WD];
   wire [5:0]  acq_ext_w  = {1'b0, ins_w[`WLAC_INS_ACQ_LO +: 4], 1'b0};
   // Acquisition length from base and field
   wire [5:0]  acq_load_w = (ins_red_w ? `WLAC_ACQ_BASE_RED
                                       : `WLAC_ACQ_BASE_FULL) + acq_ext_w;
   wire        pause_w    = (state_q == S_LOAD) & ins_w[`WLAC_INS_PAUSE];
   wire        acq_end_w  = (state_q == S_ACQ) && (acq_cnt_q == 6'h01);
   wire        got_smp_w  = (state_q == S_CONV) & sample_valid_in;
   wire [7:0]  lo_set_w   = ((state_q == S_CMP1) && cross1_w) ?
                            (8'h01 << ptr_q) : 8'h00;
   wire [7:0]  hi_set_w   = ((state_q == S_CMP2) && cross2_w) ?
                            (8'h01 << ptr_q) : 8'h00;
   wire [15:0] set_vec_w  = {hi_set_w, lo_set_w};
   // Only bits already returned to software are cleared, so a crossing that
   // lands between data capture and the read's end is kept
   wire [15:0] rd_clr_w   = (rd_done_w & hit_flag_w) ? prdata_q[15:0]
                                                     : 16'h0000;
   wire [IRQ_W-1:0] irq_set_w;
   wire [IRQ_W-1:0] irq_clr_w = (wr_done_w & hit_clr_w) ?
                                pwdata_in[IRQ_W-1:0] : '0;

   assign irq_set_w[`WLAC_IRQ_LIMIT] = |set_vec_w;
   assign irq_set_w[`WLAC_IRQ_PAUSE] = pause_w;
   assign irq_set_w[`WLAC_IRQ_CONV]  = got_smp_w;

   assign flags_d    = (flags_q & ~rd_clr_w) | set_vec_w;
   assign irq_stat_d = (irq_stat_q & ~irq_clr_w) | irq_set_w;

   // One held sample feeds both checks
   wlac_limit_cmp u_cmp1 (
      .limit_word_in (lim1_mem[ptr_q]),
      .sample_in     (sample_q),
      .crossed_out   (cross1_w)
   );
   wlac_limit_cmp u_cmp2 (
      .limit_word_in (lim2_mem[ptr_q]),
      .sample_in     (sample_q),
      .crossed_out   (cross2_w)
   );

   wlac_mux_decode #(.SEL_W(3)) u_mux (
      .pos_sel_in     (route_src_w[`WLAC_INS_POS_LO +: 3]),
      .neg_sel_in     (route_src_w[`WLAC_INS_NEG_LO +: 3]),
      .pos_route_out  (pos_route_w),
      .neg_route_out  (neg_route_w),
      .neg_ground_out (neg_gnd_w)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: state_d = run_q ? S_LOAD : S_IDLE;
         S_LOAD: state_d = ins_w[`WLAC_INS_PAUSE] ? S_NEXT : S_ACQ;
         S_ACQ:  state_d = acq_end_w ? S_CONV : S_ACQ;
         S_CONV: begin
            if (sample_valid_in) begin
               state_d = instr_q[`WLAC_INS_WD] ? S_CMP1 : S_NEXT;
            end
         end
         S_CMP1: state_d = S_CMP2;
         S_CMP2: state_d = S_NEXT;
         S_NEXT: state_d = (run_q && !pause_w) ? S_LOAD : S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   // Register file
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         run_q    <= 1'b0;
         bank_q   <= `WLAC_BANK_INSTR;
         irq_en_q <= '0;
      end else begin
         if (wr_done_w && hit_ctrl_w) begin
            run_q  <= pwdata_in[`WLAC_CTRL_START];
            bank_q <= pwdata_in[`WLAC_CTRL_BANK_LO +: 2];
         end else if (pause_w) begin
            run_q  <= 1'b0;
         end
         // Kept apart so a pause never swallows an enable write
         if (wr_done_w && hit_en_w) begin
            irq_en_q <= pwdata_in[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            instr_mem[i] <= `WLAC_RESET_WORD;
            lim1_mem[i]  <= `WLAC_RESET_WORD;
            lim2_mem[i]  <= `WLAC_RESET_WORD;
         end
      end else if (ram_wr_w && bank_q == `WLAC_BANK_INSTR) begin
         instr_mem[ram_idx_w] <= pwdata_in[15:0];
      end else if (ram_wr_w && bank_q == `WLAC_BANK_LIM1) begin
         lim1_mem[ram_idx_w]  <= pwdata_in[15:0];
      end else if (ram_wr_w && bank_q == `WLAC_BANK_LIM2) begin
         lim2_mem[ram_idx_w]  <= pwdata_in[15:0];
      end
   end

   // Answer one cycle into the access phase
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= answer_w;
         pslverr_q <= answer_w & ~mapped_w;
         if (answer_w && !pwrite_in) begin
            prdata_q <= rd_data_w;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         flags_q    <= 16'h0000;
         irq_stat_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         flags_q    <= flags_d;
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_q & irq_en_q);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         state_q   <= S_IDLE;
         ptr_q     <= 3'h0;
         instr_q   <= 16'h0000;
         acq_cnt_q <= 6'h00;
         sample_q  <= '0;
      end else begin
         state_q <= state_d;
         if (state_q == S_LOAD) begin
            instr_q   <= ins_w;
            acq_cnt_q <= acq_load_w;
         end else if (state_q == S_ACQ) begin
            acq_cnt_q <= acq_cnt_q - 6'h01;
         end
         if (got_smp_w) begin
            sample_q <= sample_in;
         end
         if (state_q == S_NEXT) begin
            ptr_q <= instr_q[`WLAC_INS_LOOP] ? 3'h0 : ptr_q + 3'h1;
         end
      end
   end

   // Pins follow the next state so they align with the phase
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         sh_acq_q     <= 1'b0;
         conv_start_q <= 1'b0;
         reduced_q    <= 1'b0;
         pos_route_q  <= 8'h00;
         neg_route_q  <= 8'h00;
         neg_gnd_q    <= 1'b0;
      end else begin
         sh_acq_q     <= (state_d == S_ACQ);
         conv_start_q <= acq_end_w;
         reduced_q    <= route_src_w[`WLAC_INS_RES];
         pos_route_q  <= pos_route_w;
         neg_route_q  <= neg_route_w;
         neg_gnd_q    <= neg_gnd_w;
      end
   end

   assign prdata_out      = prdata_q;
   assign pready_out      = pready_q;
   assign pslverr_out     = pslverr_q;
   assign irq_out         = irq_q;
   assign sh_acquire_out  = sh_acq_q;
   assign conv_start_out  = conv_start_q;
   assign reduced_res_out = reduced_q;
   assign pos_route_out   = pos_route_q;
   assign neg_route_out   = neg_route_q;
   assign neg_ground_out  = neg_gnd_q;

   // Checking helpers: acquisition length seen at the pin
   logic [5:0] acq_len_q;
   logic [5:0] acq_exp_q;
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         acq_len_q <= 6'h00;
         acq_exp_q <= 6'h00;
      end else begin
         acq_len_q <= sh_acq_q ? acq_len_q + 6'h01 : 6'h00;
         if (state_q == S_LOAD) begin
            acq_exp_q <= acq_load_w;
         end
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_flag_lo_set: assert property (
      (state_q == S_CMP1 && cross1_w) |=> flags_q[$past(ptr_q)])
      else $error("limit one crossing did not set its flag");
   a_flag_hi_set: assert property (
      (state_q == S_CMP2 && cross2_w) |=> flags_q[8 + $past(ptr_q)])
      else $error("limit two crossing did not set its flag");
   a_flag_only_hw: assert property (
      ((flags_q & ~$past(flags_q)) != 16'h0000) |-> ($past(set_vec_w) != 0))
      else $error("limit flag rose without a crossing");
   a_acq_length: assert property (
      $fell(sh_acq_q) |-> (acq_len_q == acq_exp_q))
      else $error("acquisition length wrong");
   a_acq_field: assert property (
      (state_q == S_LOAD && !ins_w[`WLAC_INS_PAUSE] && !ins_red_w)
      |=> (acq_cnt_q == 6'h09 + {1'b0, $past(ins_w[15:12]), 1'b0}))
      else $error("acquisition field misread");
   a_bank_lim1: assert property (
      (answer_w && !pwrite_in && hit_ram_w && bank_q == 2'h1)
      |=> (prdata_q[15:0] == $past(lim1_mem[ram_idx_w])))
      else $error("bank one read wrong array");
   a_bank_lim2: assert property (
      (answer_w && !pwrite_in && hit_ram_w && bank_q == 2'h2)
      |=> (prdata_q[15:0] == $past(lim2_mem[ram_idx_w])))
      else $error("bank two read wrong array");
   a_same_sample: assert property (
      (state_q == S_CMP1) |=> (state_q == S_CMP2) && $stable(sample_q))
      else $error("second check used another sample");
   a_gnd_route: assert property (
      (route_src_w[`WLAC_INS_NEG_LO +: 3] == 3'h0)
      |=> neg_gnd_q && (neg_route_q == 8'h00))
      else $error("negative select zero not grounded");
   a_irq_limit: assert property (
      (set_vec_w != 16'h0000) |=> irq_stat_q[`WLAC_IRQ_LIMIT] ##1
      (irq_out || !$past(irq_en_q[`WLAC_IRQ_LIMIT])))
      else $error("crossing did not flag interrupt");
   a_clear_read: assert property (
      (rd_done_w && hit_flag_w && set_vec_w == 16'h0000)
      |=> ((flags_q & $past(prdata_q[15:0])) == 16'h0000))
      else $error("read did not clear returned flags");
endmodule // wlac_ctrl

//--- wlac_conv_model.sv
// Behavioural converter model at the far side of the acquisition control.
// Assumes one conv_start pulse per conversion and a bench-chosen sample.
module wlac_conv_model (
   input  wire logic                   clk_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   conv_start_in,
   input  wire logic            [3:0]  delay_in,
   input  wire wlac_pkg::wlac_sample_t value_in,
   output logic                        valid_out,
   output wlac_pkg::wlac_sample_t      sample_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import wlac_pkg::*;
   logic       busy_q;
   logic [3:0] wait_q;
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         busy_q     <= 1'b0;
         wait_q     <= 4'h0;
         valid_out  <= 1'b0;
         sample_out <= '0;
      end else begin
         valid_out  <= 1'b0;
         // Data toggles when not valid, so a stale value looks right only in alternate cycles
         sample_out <= ~sample_out;
         if (conv_start_in) begin
            busy_q <= 1'b1;
            wait_q <= delay_in;
         end else if (busy_q && wait_q == 4'h0) begin
            valid_out  <= 1'b1;
            sample_out <= value_in;
            busy_q     <= 1'b0;
         end else if (busy_q) begin
            wait_q <= wait_q - 4'h1;
         end
      end
   end
endmodule // wlac_conv_model

//--- tb_top.sv
// Self-checking bench for the acquisition control over APB.
// Assumes the converter model answers each conversion request.
`include "wlac_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wlac_pkg::*;
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, irq, sv, acq, cs, red, gnd;
   logic [7:0]  pos, neg;
   logic [3:0]  delay = 4'h0;
   wlac_sample_t smp, cur_smp = '0;
   wlac_word_t ins [8], l1 [8], l2 [8], mw;
   wlac_sample_t samp [8];
   int run_q [$];
   int run_pos = 0, acq_cnt = 0, cyc = 0, errors = 0, tests_run = 0, idx;
   wlac_ctrl wlac_ctrl_inst (.ref_clk_in(clk), .rst_b_in(rst_b),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
      .sample_valid_in(sv), .sample_in(smp), .sh_acquire_out(acq),
      .conv_start_out(cs), .reduced_res_out(red), .pos_route_out(pos),
      .neg_route_out(neg), .neg_ground_out(gnd));
   wlac_conv_model wlac_conv_model_inst (.clk_in(clk), .rst_b_in(rst_b),
      .conv_start_in(cs), .delay_in(delay), .value_in(cur_smp),
      .valid_out(sv), .sample_out(smp));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   function automatic logic crossed(wlac_word_t lw, wlac_sample_t s);
      int lim;
      lim = lw[8] ? -int'(lw[7:0]) : int'(lw[7:0]);
      return lw[9] ? (int'(s) > lim) : (int'(s) < lim);
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   // Reference model of each acquisition, routes checked as it starts, length as it ends
   always @(posedge clk) begin
      if (rst_b && acq === 1'b1) begin
         if (acq_cnt == 0) begin
            idx = (run_pos < run_q.size()) ? run_q[run_pos] : 0;
            mw = ins[idx];
            check(32'(pos), 32'(8'h01 << mw[4:2]));
            check(32'(neg), mw[7:5] == 0 ? 0 : 32'(8'h01 << mw[7:5]));
            check(32'(gnd), 32'(mw[7:5] == 3'h0));
            check(32'(red), 32'(mw[10]));
         end
         acq_cnt++;
      end else if (rst_b && acq_cnt != 0) begin
         check(32'(acq_cnt), (mw[11] | mw[10]) ? 2 + 2 * mw[15:12]
                                             : 9 + 2 * mw[15:12]);
         check(32'(cs), 32'h1);
         cur_smp <= samp[idx];
         acq_cnt = 0;
         run_pos++;
      end
   end
   task automatic run_pass(input int p);
      logic [31:0] v, exp;
      logic        any;
      int          k;
      exp = 0;
      for (int i = 0; i < 8; i++) begin
         v = $urandom;
         l1[i] = {6'h00, v[25:16]};
         l2[i] = {6'h00, v[9:0]};
         samp[i] = wlac_sample_t'(v[30:22]);
         v = $urandom;
         // Extension spans 0..15, covering any software choice
         ins[i] = {v[15:12], v[11] | v[20], v[10], 2'b00, v[7:2],
                   i == p, p == 0 && i == 5};
      end
      for (int b = 0; b < 3; b++) begin
         apb(1, `WLAC_OFF_CTRL, 32'(b) << `WLAC_CTRL_BANK_LO);
         for (int i = 0; i < 8; i++) begin
            v = {16'h0, b == 0 ? ins[i] : b == 1 ? l1[i] : l2[i]};
            apb(1, {`WLAC_RAM_PAGE, 3'(i), 2'b00}, v);
            apb(0, {`WLAC_RAM_PAGE, 3'(i), 2'b00}, 32'h0);
            check(r, v);
         end
      end
      apb(1, `WLAC_OFF_CTRL, 32'h300);
      apb(0, {`WLAC_RAM_PAGE, 5'h00}, 32'h0);
      check(r, 32'h0);
      run_q.delete();
      run_pos = 0;
      // Second pass loops back at five, so it runs one to five only
      for (int i = 0; i < (p == 7 ? 7 : 5); i++) begin
         run_q.push_back(p == 7 ? i : i + 1);
      end
      delay <= (p == 7) ? 4'h0 : 4'h5;
      apb(1, `WLAC_OFF_IRQ_EN, 32'h1);
      repeat (p == 7 ? 1 : 2) begin
         apb(1, `WLAC_OFF_CTRL, 32'h1);
         for (k = 0; k < 300; k++) begin
            apb(0, `WLAC_OFF_SEQ_STAT, 32'h0);
            if (r[3] === 1'b0) break;
         end
         if (k == 300) errors++;
      end
      check(32'(run_pos), p == 7 ? 32'd7 : 32'd5);
      // Pointer steps past the pause, wrapping from seven in the first pass
      check(32'(r[2:0]), p == 7 ? 32'd0 : 32'd1);
      foreach (run_q[j]) begin
         if (ins[run_q[j]][11]) begin
            if (crossed(l1[run_q[j]], samp[run_q[j]])) exp[run_q[j]] = 1;
            if (crossed(l2[run_q[j]], samp[run_q[j]])) exp[run_q[j]+8] = 1;
         end
      end
      any = exp != 0;
      apb(0, `WLAC_OFF_LIMFLAG, 32'h0);
      check(r, exp);
      apb(0, `WLAC_OFF_LIMFLAG, 32'h0);
      check(r, 32'h0);
      check(32'(irq), 32'(any));
      apb(0, `WLAC_OFF_IRQ_STAT, 32'h0);
      check(32'(r[2:0]), 32'(3'b110 | any));
      apb(1, `WLAC_OFF_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0);
      apb(1, `WLAC_OFF_IRQ_CLR, 32'h7);
      apb(0, `WLAC_OFF_IRQ_STAT, 32'h0);
      check(32'(r[2:0]), 32'h0);
      $display("test pass with pause at %0d done", p);
   endtask
   initial begin
      r = $urandom(46);
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      apb(0, `WLAC_OFF_LIMFLAG, 32'h0);
      check(r, 32'h0);
      apb(0, `WLAC_OFF_IRQ_STAT, 32'h0);
      check(r, 32'h0);
      apb(0, 8'h30, 32'h0);
      check({r[30:0], pslverr}, 32'h1);
      apb(1, `WLAC_OFF_LIMFLAG, 32'hffff);
      apb(0, `WLAC_OFF_LIMFLAG, 32'h0);
      check(r, 32'h0);
      $display("test reset and access done");
      run_pass(7);
      run_pass(0);
      print_verdict();
   end
endmodule // tb_top
